// ===== cabp_port.v
`timescale 1ns/1ps
`default_nettype none
`include "cabp_defs.vh"

module cabp_port #(
  parameter PULLUP_CYCLES = `CABP_PULLUP_CYCLES
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // configuration straps
  input wire i_size_n,
  input wire i_low_address_bit,
  // host bus control
  input wire i_address_strobe_n,
  input wire i_data_strobe_n,
  input wire i_chip_select_n,
  input wire i_read_write,
  input wire [`CABP_ADDR_W-1:0] i_addr,
  // data bus, three signals
  input wire [31:0] i_data,
  output reg [31:0] o_data,
  output reg o_data_oe,
  // acknowledges, two signals each
  output reg o_transfer_ack_low_n,
  output reg o_transfer_ack_low_oe,
  output reg o_transfer_ack_high_n,
  output reg o_transfer_ack_high_oe,
  // core side
  input wire i_core_ready,
  output reg o_core_wr,
  output reg o_core_rd,
  output reg [3:0] o_core_idx,
  output reg o_core_byte_sel,
  output reg [31:0] o_core_wdata,
  input wire [31:0] i_core_rdata
);

  // ==========================================================
  // states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_ACK = 4'b0100;
  localparam [3:0] ST_PULL = 4'b1000;

  // ==========================================================
  // acknowledge codes, active low {high, low}
  localparam [1:0] ACK_FULL = 2'b00;
  localparam [1:0] ACK_UPPER = 2'b01;
  localparam [1:0] ACK_LOWER = 2'b10;
  localparam [1:0] ACK_NONE = 2'b11;
  // timer load, cut to the counter width on purpose
  localparam [3:0] PULL_LOAD = PULLUP_CYCLES[3:0];

  // ==========================================================
  // synchronised strobes; the host keeps address stable while strobe low
  wire [3:0] sync_w;
  wire as_n;
  wire ds_n;
  wire cs_n;
  wire rw;

  cabp_sync #(
    .WIDTH(4),
    .INIT(4'hf)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_async({i_address_strobe_n, i_data_strobe_n, i_chip_select_n, i_read_write}),
    .o_sync(sync_w)
  );

  assign as_n = sync_w[3];
  assign ds_n = sync_w[2];
  assign cs_n = sync_w[1];
  assign rw = sync_w[0];

  // ==========================================================
  // straps caught after reset release, treated as static
  // a strap moved later is only seen after the next reset
  reg [1:0] width_reg;
  reg strap_taken_reg;

  function [1:0] width_of;
    input size_n;
    input low_bit;
    begin
      if (!size_n)
        width_of = `CABP_WIDTH_8;
      else if (!low_bit)
        width_of = `CABP_WIDTH_16;
      else
        width_of = `CABP_WIDTH_32;
    end
  endfunction

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      width_reg <= `CABP_WIDTH_32;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      width_reg <= width_of(i_size_n, i_low_address_bit);
      strap_taken_reg <= 1'b1;
    end
  end

  // ==========================================================
  // full-word cycle: 32-bit port and upper register block
  function full_port;
    input [1:0] width;
    input top_sel;
    begin
      full_port = (width == `CABP_WIDTH_32) && top_sel;
    end
  endfunction

  // ==========================================================
  // acknowledge pattern per port width
  function [1:0] ack_pattern;
    input [1:0] width;
    input top_sel;
    begin
      case (width)
        `CABP_WIDTH_32: ack_pattern = full_port(width, top_sel) ? ACK_FULL : ACK_UPPER;
        `CABP_WIDTH_16: ack_pattern = ACK_UPPER;
        `CABP_WIDTH_8: ack_pattern = ACK_LOWER;
        default: ack_pattern = ACK_NONE;
      endcase
    end
  endfunction

  // read data lane placement
  function [31:0] lane_place;
    input [1:0] width;
    input top_sel;
    input byte_sel;
    input [31:0] word;
    begin
      if (width == `CABP_WIDTH_8)
        lane_place = byte_sel ? {4{word[23:16]}} : {4{word[31:24]}};
      else if (full_port(width, top_sel))
        lane_place = word;
      else
        lane_place = {word[31:16], 16'h0000};
    end
  endfunction

  // ==========================================================
  // cycle state machine
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [3:0] pull_cnt_reg;
  wire cycle_on;
  wire strobe_end;
  wire top_sel;
  // direction and upper block held from the take edge, pins may move later
  reg dir_read_reg;
  reg top_sel_reg;

  assign top_sel = i_addr[`CABP_TOP_SEL_BIT];
  assign cycle_on = !as_n && !cs_n;
  // a write waits for data strobe, data is valid only then;
  // address strobe rising, data strobe rising on a write, or select dropping, ends the answer
  assign strobe_end = as_n || cs_n || (!dir_read_reg && ds_n);

  // ==========================================================
  // next-state logic
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cycle_on && (rw || !ds_n))
          state_next = ST_WAIT;
      end
      ST_WAIT: begin
        // host gave up before ready: release without acknowledging
        if (as_n || cs_n)
          state_next = ST_PULL;
        else if (i_core_ready)
          state_next = ST_ACK;
      end
      ST_ACK: begin
        if (strobe_end)
          state_next = ST_PULL;
      end
      ST_PULL: begin
        if (pull_cnt_reg == 4'h0)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ==========================================================
  // bus-side outputs and core strobes
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      dir_read_reg <= 1'b1;
      top_sel_reg <= 1'b0;
      o_transfer_ack_low_n <= 1'b1;
      o_transfer_ack_high_n <= 1'b1;
      o_transfer_ack_low_oe <= 1'b0;
      o_transfer_ack_high_oe <= 1'b0;
      o_data <= `CABP_RESET_WORD;
      o_data_oe <= 1'b0;
      o_core_wr <= 1'b0;
      o_core_rd <= 1'b0;
      o_core_idx <= 4'h0;
      o_core_byte_sel <= 1'b0;
      o_core_wdata <= `CABP_RESET_WORD;
    end else begin
      state_reg <= state_next;
      o_core_wr <= 1'b0;
      o_core_rd <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          o_transfer_ack_low_oe <= 1'b0;
          o_transfer_ack_high_oe <= 1'b0;
          o_data_oe <= 1'b0;
          if (state_next == ST_WAIT) begin
            o_core_idx <= i_addr[`CABP_REG_IDX_HI:`CABP_REG_IDX_LO];
            o_core_byte_sel <= i_addr[`CABP_LOW_ADDR_BIT];
            dir_read_reg <= rw;
            top_sel_reg <= top_sel;
            // acks driven negated while waiting, host inserts waits
            o_transfer_ack_low_n <= 1'b1;
            o_transfer_ack_high_n <= 1'b1;
            o_transfer_ack_low_oe <= 1'b1;
            o_transfer_ack_high_oe <= 1'b1;
            o_core_rd <= rw;
          end
        end
        ST_WAIT: begin
          if (state_next == ST_ACK) begin
            {o_transfer_ack_high_n, o_transfer_ack_low_n} <=
              ack_pattern(width_reg, top_sel_reg);
            if (dir_read_reg) begin
              // data launched on the ack edge, so it is valid with the ack
              o_data <=
                lane_place(width_reg, top_sel_reg, o_core_byte_sel, i_core_rdata);
              o_data_oe <= 1'b1;
            end else begin
              o_core_wr <= 1'b1;
              o_core_wdata <= i_data;
            end
          end
        end
        ST_ACK: begin
          if (strobe_end) begin
            o_transfer_ack_low_n <= 1'b1;
            o_transfer_ack_high_n <= 1'b1;
            o_data_oe <= 1'b0;
          end
        end
        ST_PULL: begin
          o_transfer_ack_low_n <= 1'b1;
          o_transfer_ack_high_n <= 1'b1;
          o_data_oe <= 1'b0;
          if (pull_cnt_reg == 4'h0) begin
            o_transfer_ack_low_oe <= 1'b0;
            o_transfer_ack_high_oe <= 1'b0;
          end
        end
        default: begin
          o_transfer_ack_low_oe <= 1'b0;
          o_transfer_ack_high_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // pull-up timer: loaded while waiting, run down after the strobe
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      pull_cnt_reg <= 4'h0;
    end else if (state_reg == ST_WAIT) begin
      pull_cnt_reg <= PULL_LOAD;
    end else if (state_reg == ST_PULL && pull_cnt_reg != 4'h0) begin
      pull_cnt_reg <= pull_cnt_reg - 4'h1;
    end
  end

endmodule

`default_nettype wire

// ===== cabp_defs.vh
`ifndef CABP_DEFS_VH
`define CABP_DEFS_VH

// ==========================================================
// port width codes
`define CABP_WIDTH_8 2'h0
`define CABP_WIDTH_16 2'h1
`define CABP_WIDTH_32 2'h2

// ==========================================================
// address map fields
`define CABP_ADDR_W 5
`define CABP_TOP_SEL_BIT 4
`define CABP_LOW_ADDR_BIT 0
`define CABP_REG_IDX_HI 4
`define CABP_REG_IDX_LO 1

// ==========================================================
// register indices, address bits 4..1
`define CABP_IDX_RESPONSE 4'h0
`define CABP_IDX_CONTROL 4'h1
`define CABP_IDX_SAVE 4'h2
`define CABP_IDX_RESTORE 4'h3
`define CABP_IDX_COMMAND 4'h5
`define CABP_IDX_CONDITION 4'h7
`define CABP_IDX_OPERAND 4'h8
`define CABP_IDX_REGSEL 4'ha
`define CABP_IDX_INSTADDR 4'hc
`define CABP_IDX_OPADDR 4'he

// ==========================================================
// timing counts
`define CABP_PULLUP_CYCLES 4'h4
`define CABP_RESET_WORD 32'h0000_0000

`endif

// ===== cabp_sync.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// two-flop synchroniser, reset to a given level
module cabp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // levels
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] stage_reg;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      stage_reg <= INIT;
      o_sync <= INIT;
    end else begin
      stage_reg <= i_async;
      o_sync <= stage_reg;
    end
  end
endmodule

`default_nettype wire

// ===== cabp_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// ack checks at the pins
module cabp_port_monitor (
  // host side
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_size_n,
  input wire logic i_low_address_bit,
  input wire logic i_address_strobe_n,
  input wire logic i_chip_select_n,
  input wire logic [4:0] i_addr,
  input wire logic i_core_ready,
  // device side
  input wire logic o_transfer_ack_low_n,
  input wire logic o_transfer_ack_low_oe,
  input wire logic o_transfer_ack_high_n,
  input wire logic o_transfer_ack_high_oe
);
  wire lo = o_transfer_ack_low_oe && !o_transfer_ack_low_n;
  wire hi = o_transfer_ack_high_oe && !o_transfer_ack_high_n;
  wire ak = lo || hi;
  wire en = o_transfer_ack_low_oe || o_transfer_ack_high_oe;
  wire wide = i_size_n && i_low_address_bit;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_sel; $rose(en) |-> $past(i_chip_select_n, 2) == 1'b0; endproperty
  a_sel: assert property (p_sel) else $error("ack w/o select");
  // ready low stretches the answer, so it is left out of the bound
  property p_ans;
    $fell(i_address_strobe_n) && !i_chip_select_n && i_core_ready |-> ##[2:8] ak;
  endproperty
  a_ans: assert property (p_ans) else $error("no ack");
  property p_full; hi && lo |-> wide && i_addr[4]; endproperty
  a_full: assert property (p_full) else $error("both acks");
  property p_half; hi && wide && !i_addr[4] |-> !lo; endproperty
  a_half: assert property (p_half) else $error("low ack on half");
  property p_w16; hi && i_size_n && !i_low_address_bit |-> !lo; endproperty
  a_w16: assert property (p_w16) else $error("low ack at 16");
  property p_w8; !i_size_n |-> !hi; endproperty
  a_w8: assert property (p_w8) else $error("high ack at 8");
  property p_pull; ak ##1 !ak |-> en && o_transfer_ack_low_n && o_transfer_ack_high_n; endproperty
  a_pull: assert property (p_pull) else $error("no pull-up");
  property p_rel; $rose(i_address_strobe_n) |-> ##[1:12] !en; endproperty
  a_rel: assert property (p_rel) else $error("acks held");
  c_full: cover property (hi && lo);
  c_byte: cover property (lo && !hi);
  c_half: cover property (hi && !lo);
endmodule
`default_nettype wire

// ===== cabp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// host master, one bus cycle per call
module cabp_host_model (
  // replies
  input wire logic i_clk_sys,
  input wire logic [1:0] i_ack_n,
  input wire logic [31:0] i_data,
  // bus pins
  output var logic o_strobe_n = 1'b1,
  output var logic o_dstrobe_n = 1'b1,
  output var logic o_select_n = 1'b1,
  output var logic o_rw = 1'b1,
  output var logic [4:0] o_addr = 5'h00,
  output var logic [31:0] o_data = 32'h0
);
  // select, direction and address change with the strobe
  task automatic xfer(input logic cs, input logic r, input logic [4:0] a,
    input logic [31:0] w, output logic [1:0] ack, output logic [31:0] rd);
    @(posedge i_clk_sys);
    o_select_n <= cs;
    o_rw <= r;
    o_addr <= a;
    o_data <= r ? ~o_data : w;
    o_strobe_n <= 1'b0;
    o_dstrobe_n <= r;
    ack = 2'h3;
    for (int n = 0; n < 12 && ack == 2'h3; n++) begin
      @(posedge i_clk_sys);
      ack = i_ack_n;
      rd = i_data;
    end
    o_strobe_n <= 1'b1;
    o_dstrobe_n <= 1'b1;
    o_select_n <= 1'b1;
    // released bus flips so a stale word cannot pass
    o_data <= ~o_data;
    repeat (10) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// ===== tb_coproc_async_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// bench: host model against the port
module tb_coproc_async_bus_port;
  logic clk = 1'b0, rst = 1'b1, sz = 1'b1, lb = 1'b1, rdy = 1'b1;
  logic [31:0] rdata = 32'ha1b2_c3d4;
  logic [1:0] ack;
  logic [31:0] rd;
  int errors = 0, n_tests = 0;
  int n_rd = 0, n_wr = 0;
  wire stb_n, dstb_n, sel_n, rw, al_n, al_oe, ah_n, ah_oe, doe, cwr, crd, cbs;
  wire [4:0] ad;
  wire [3:0] cidx;
  wire [31:0] hd, dd, cwd;
  // holding resistor keeps released acks high
  wire [1:0] ackw = {ah_oe ? ah_n : 1'b1, al_oe ? al_n : 1'b1};
  // undriven data bus reads back inverted, so a missing drive shows
  wire [31:0] hbus = doe ? dd : ~dd;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (crd)
      n_rd <= n_rd + 1;
    if (cwr)
      n_wr <= n_wr + 1;
  end
  cabp_port #(.PULLUP_CYCLES(1)) uut (.i_clk_sys(clk), .i_reset(rst), .i_size_n(sz),
    .i_low_address_bit(lb), .i_address_strobe_n(stb_n), .i_data_strobe_n(dstb_n),
    .i_chip_select_n(sel_n), .i_read_write(rw), .i_addr(ad), .i_data(hd), .o_data(dd),
    .o_data_oe(doe), .o_transfer_ack_low_n(al_n), .o_transfer_ack_low_oe(al_oe),
    .o_transfer_ack_high_n(ah_n), .o_transfer_ack_high_oe(ah_oe), .i_core_ready(rdy),
    .o_core_wr(cwr), .o_core_rd(crd), .o_core_idx(cidx), .o_core_byte_sel(cbs),
    .o_core_wdata(cwd),
    .i_core_rdata(rdata));
  cabp_host_model host (.i_clk_sys(clk), .i_ack_n(ackw), .i_data(hbus), .o_strobe_n(stb_n),
    .o_dstrobe_n(dstb_n), .o_select_n(sel_n), .o_rw(rw), .o_addr(ad), .o_data(hd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // straps are only taken at reset release
  task automatic boot(input logic s, input logic l);
    @(posedge clk);
    rst <= 1'b1;
    sz <= s;
    lb <= l;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [1:0] ea, input logic [31:0] ed, m);
    int r0;
    r0 = n_rd;
    host.xfer(1'b0, 1'b1, a, 32'h0, ack, rd);
    chk({30'h0, ack}, {30'h0, ea});
    chk(rd & m, ed & m);
    chk({27'h0, cidx, cbs}, {27'h0, a});
    chk(n_rd - r0, 32'h1);
    chk({31'h0, doe}, 32'h0);
  endtask
  task automatic t_sizes();
    boot(1'b1, 1'b1);
    rdc(5'h10, 2'h0, rdata, 32'hffff_ffff);
    rdc(5'h02, 2'h1, rdata, 32'hffff_0000);
    boot(1'b1, 1'b0);
    rdc(5'h03, 2'h1, rdata, 32'hffff_0000);
    boot(1'b0, 1'b0);
    rdc(5'h00, 2'h2, {4{rdata[31:24]}}, 32'hffff_ffff);
    rdc(5'h01, 2'h2, {4{rdata[23:16]}}, 32'hffff_ffff);
  endtask
  task automatic t_write();
    int w0;
    boot(1'b1, 1'b1);
    w0 = n_wr;
    host.xfer(1'b0, 1'b0, 5'h10, 32'h5a5a_0ff0, ack, rd);
    chk({30'h0, ack}, 32'h0);
    chk(cwd, 32'h5a5a_0ff0);
    chk(n_wr - w0, 32'h1);
  endtask
  task automatic t_refuse();
    int r0;
    r0 = n_rd;
    host.xfer(1'b1, 1'b1, 5'h10, 32'h0, ack, rd);
    chk({30'h0, ack}, 32'h3);
    chk(n_rd - r0, 32'h0);
  endtask
  task automatic t_wait();
    @(posedge clk);
    rdy <= 1'b0;
    fork
      host.xfer(1'b0, 1'b1, 5'h10, 32'h0, ack, rd);
      begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({27'h0, doe, ah_oe, al_oe, ah_n, al_n}, 32'hf);
        @(posedge clk);
        rdy <= 1'b1;
      end
    join
    chk({30'h0, ack}, 32'h0);
  endtask
  task automatic end_of_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    t_sizes();
    t_write();
    t_refuse();
    t_wait();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule
bind cabp_port cabp_port_monitor mon (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_size_n(i_size_n), .i_low_address_bit(i_low_address_bit),
  .i_address_strobe_n(i_address_strobe_n), .i_chip_select_n(i_chip_select_n),
  .i_addr(i_addr), .i_core_ready(i_core_ready),
  .o_transfer_ack_low_n(o_transfer_ack_low_n),
  .o_transfer_ack_low_oe(o_transfer_ack_low_oe),
  .o_transfer_ack_high_n(o_transfer_ack_high_n),
  .o_transfer_ack_high_oe(o_transfer_ack_high_oe));
`default_nettype wire
